// ==== include/dat_pkg.sv ====
// Constants for the dual-mode auto-reload timer.
// Assumes an 8-bit special function register port clocked by I_CLK_SYS.
// Summary of operation
// [R1] Split clear: 16-bit count; wrap reloads both bytes, sets high flag.
// [R2] 16-bit mode: irq enable requests interrupt on each full overflow.
// [R3] 16-bit mode: low-byte wrap also interrupts when low irq enable set.
// [R4] Split set: two independent 8-bit timers, each reloads its own byte.
// [R5] Split mode: run control gates only the high byte; low always runs.
// [R6] Split mode: each byte picks clock from its fast bit and alternate bit.
// [R7] External clock/8 source is synchronised before it advances counts.
// [R8] High flag on high byte wrap; low flag on low byte wrap, any mode.
// [R9] Split mode: interrupt on high overflow, and low overflow if enabled.
// [R10] Hardware never clears overflow flags; only a zero write does.
// [R11] Servicing software reads both flags, then clears the handled ones.
// [R12] Bits: 7,6 flags; 5 low irq; 3 split; 2 run; 0 alt; rest 0.
// [R13] Alternate select: zero picks core clock/12, one external clock/8.
// [R14] Set high flag with timer irq enabled vectors to this handler.
// [R15] 16-bit mode uses high fast select with alternate bit, gated by run.
// [R16] Capture enable is treated as zero and ignored.
package dat_pkg;
   localparam logic [7:0] ADDR_CTRL       = 8'hc8;
   localparam logic [7:0] ADDR_RELOAD_LO  = 8'hca;
   localparam logic [7:0] ADDR_RELOAD_HI  = 8'hcb;
   localparam logic [7:0] ADDR_COUNT_LO   = 8'hcc;
   localparam logic [7:0] ADDR_COUNT_HI   = 8'hcd;
   localparam int         BIT_HIGH_FLAG   = 7;
   localparam int         BIT_LOW_FLAG    = 6;
   localparam int         BIT_LOW_IRQ_EN  = 5;
   localparam int         BIT_SPLIT       = 3;
   localparam int         BIT_RUN         = 2;
   localparam int         BIT_ALT_CLK     = 0;
   localparam logic [7:0] CTRL_RESET      = 8'h00;
   localparam logic [7:0] CTRL_WRITE_MASK = 8'hed;
   localparam logic [7:0] BYTE_RESET      = 8'h00;
   localparam logic [7:0] BYTE_MAX        = 8'hff;
   localparam int         CORE_DIV        = 12;
   localparam logic [3:0] CORE_DIV_LAST   = 4'(CORE_DIV - 1);
   localparam int         EXT_DIV         = 8;
   localparam logic [2:0] EXT_DIV_LAST    = 3'(EXT_DIV - 1);
endpackage

// ==== design/dat_tick_gen.sv ====
// Count-rate enables for the timer: core clock/12 and external clock/8.
// Assumes the external oscillator is asynchronous to I_CLK_SYS.
`timescale 1ns/1ps
module dat_tick_gen
   import dat_pkg::*;
(
   input  wire logic i_clk,
   input  wire logic i_reset,
   input  wire logic i_ext_osc,
   output logic      o_tick_div12,
   output logic      o_tick_ext8
);
   logic [3:0] div12_cnt;
   logic [2:0] ext_div_cnt;
   logic       ext_sync1;
   logic       ext_sync2;
   logic       ext_prev;

   ////////////////////////////////////////////////////////////////////////
   // Core clock divided by twelve
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         div12_cnt    <= 4'h0;
         o_tick_div12 <= 1'b0;
      end
      else
      begin
         o_tick_div12 <= (div12_cnt == CORE_DIV_LAST);
         if (div12_cnt == CORE_DIV_LAST)
            div12_cnt <= 4'h0;
         else
            div12_cnt <= div12_cnt + 4'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Two-stage synchroniser for the external oscillator, see [R7]
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         ext_sync1 <= 1'b0;
         ext_sync2 <= 1'b0;
         ext_prev  <= 1'b0;
      end
      else
      begin
         ext_sync1 <= i_ext_osc;
         ext_sync2 <= ext_sync1;
         ext_prev  <= ext_sync2;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Divide synchronised rising edges by eight, see [R7]
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         ext_div_cnt <= 3'h0;
         o_tick_ext8 <= 1'b0;
      end
      else
      begin
         o_tick_ext8 <= 1'b0;
         if (ext_sync2 && !ext_prev)
         begin
            o_tick_ext8 <= (ext_div_cnt == EXT_DIV_LAST);
            ext_div_cnt <= ext_div_cnt + 3'h1;
         end
      end
   end
endmodule

// ==== design/dat_timer.sv ====
// Dual-mode auto-reload timer with its special function registers.
// Assumes a one-cycle SFR write strobe and a combinational read port.
// The interrupt enable and fast-select inputs come from other registers
// on the same clock, so they need no synchroniser.
`timescale 1ns/1ps
module dat_timer
   import dat_pkg::*;
(
   input  wire logic       I_CLK_SYS,
   input  wire logic       I_RESET,
   input  wire logic [7:0] I_SFR_ADDR,
   input  wire logic [7:0] I_SFR_WDATA,
   input  wire logic       I_SFR_WE,
   output logic      [7:0] O_SFR_RDATA,
   input  wire logic       I_EXT_OSC,
   input  wire logic       I_HIGH_FAST_CLOCK_SELECT,
   input  wire logic       I_LOW_FAST_CLOCK_SELECT,
   input  wire logic       I_TIMER_IRQ_ENABLE,
   input  wire logic       I_CAPTURE_ENABLE_BIT,
   output logic            O_IRQ
);
   // Count and reload bytes, then the control bits
   logic [7:0] count_low_byte;
   logic [7:0] count_high_byte;
   logic [7:0] reload_low_byte;
   logic [7:0] reload_high_byte;
   logic       high_overflow_flag;
   logic       low_overflow_flag;
   logic       low_overflow_irq_enable;
   logic       split_mode_select;
   logic       high_run_control;
   logic       alternate_clock_select;
   // Rate enables and per-byte advance strobes
   logic       tick_div12;
   logic       tick_ext8;
   logic       tick_high;
   logic       tick_low;
   logic       adv_low;
   logic       adv_high;
   logic       low_wrap;
   logic       high_wrap;
   // Register write strobes
   logic       wr_ctrl;
   logic       wr_cnt_lo;
   logic       wr_cnt_hi;

   // Count source pick from fast bit and alternate bit, see [R6] [R13]
   // Fast select overrides the alternate bit entirely
   function automatic logic pick_tick(input logic fast, input logic alt,
                                      input logic d12, input logic e8);
      if (fast)
         return 1'b1;
      else if (alt)
         return e8;
      else
         return d12;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Rate enables
   dat_tick_gen u_tick (
      .i_clk        (I_CLK_SYS),
      .i_reset      (I_RESET),
      .i_ext_osc    (I_EXT_OSC),
      .o_tick_div12 (tick_div12),
      .o_tick_ext8  (tick_ext8)
   );

   ////////////////////////////////////////////////////////////////////////
   // Advance conditions; capture enable is ignored, see [R16]
   assign tick_high = pick_tick(I_HIGH_FAST_CLOCK_SELECT,
                                alternate_clock_select,
                                tick_div12, tick_ext8);
   assign tick_low  = pick_tick(I_LOW_FAST_CLOCK_SELECT,
                                alternate_clock_select,
                                tick_div12, tick_ext8);
   // Low byte in split mode runs free, see [R5]; 16-bit gated, see [R15]
   assign adv_low   = split_mode_select ? tick_low
                                        : (tick_high && high_run_control);
   assign adv_high  = split_mode_select ? (tick_high && high_run_control)
                                        : (adv_low && count_low_byte == BYTE_MAX);
   assign low_wrap  = adv_low && (count_low_byte == BYTE_MAX);
   assign high_wrap = adv_high && (count_high_byte == BYTE_MAX);

   // Write decodes
   assign wr_ctrl   = I_SFR_WE && (I_SFR_ADDR == ADDR_CTRL);
   assign wr_cnt_lo = I_SFR_WE && (I_SFR_ADDR == ADDR_COUNT_LO);
   assign wr_cnt_hi = I_SFR_WE && (I_SFR_ADDR == ADDR_COUNT_HI);

   ////////////////////////////////////////////////////////////////////////
   // Control bits, see [R12]
   // Flags live in their own process so hardware sets can win
   always_ff @(posedge I_CLK_SYS)
   begin
      if (I_RESET)
      begin
         low_overflow_irq_enable <= CTRL_RESET[BIT_LOW_IRQ_EN];
         split_mode_select       <= CTRL_RESET[BIT_SPLIT];
         high_run_control        <= CTRL_RESET[BIT_RUN];
         alternate_clock_select  <= CTRL_RESET[BIT_ALT_CLK];
      end
      else if (wr_ctrl)
      begin
         low_overflow_irq_enable <= I_SFR_WDATA[BIT_LOW_IRQ_EN];
         split_mode_select       <= I_SFR_WDATA[BIT_SPLIT];
         high_run_control        <= I_SFR_WDATA[BIT_RUN];
         alternate_clock_select  <= I_SFR_WDATA[BIT_ALT_CLK];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Overflow flags: set wins over a software clear, see [R8] [R10]
   always_ff @(posedge I_CLK_SYS)
   begin
      if (I_RESET)
      begin
         high_overflow_flag <= CTRL_RESET[BIT_HIGH_FLAG];
         low_overflow_flag  <= CTRL_RESET[BIT_LOW_FLAG];
      end
      else
      begin
         if (high_wrap)
            high_overflow_flag <= 1'b1;          // see [R1] [R8]
         else if (wr_ctrl)
            high_overflow_flag <= I_SFR_WDATA[BIT_HIGH_FLAG];
         if (low_wrap)
            low_overflow_flag <= 1'b1;           // see [R8]
         else if (wr_ctrl)
            low_overflow_flag <= I_SFR_WDATA[BIT_LOW_FLAG];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Reload bytes
   // Taken only on a wrap, so a new value applies from the next wrap
   always_ff @(posedge I_CLK_SYS)
   begin
      if (I_RESET)
      begin
         reload_low_byte  <= BYTE_RESET;
         reload_high_byte <= BYTE_RESET;
      end
      else if (I_SFR_WE)
      begin
         if (I_SFR_ADDR == ADDR_RELOAD_LO)
            reload_low_byte <= I_SFR_WDATA;
         if (I_SFR_ADDR == ADDR_RELOAD_HI)
            reload_high_byte <= I_SFR_WDATA;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Low count byte
   // A software write wins over a count in the same cycle
   // In 16-bit mode a low-only wrap rolls to zero and carries upward
   always_ff @(posedge I_CLK_SYS)
   begin
      if (I_RESET)
         count_low_byte <= BYTE_RESET;
      else if (wr_cnt_lo)
         count_low_byte <= I_SFR_WDATA;
      else if (adv_low)
      begin
         if (!low_wrap)
            count_low_byte <= count_low_byte + 8'h01;
         else if (split_mode_select)
            count_low_byte <= reload_low_byte;   // see [R4]
         else if (count_high_byte == BYTE_MAX)
            count_low_byte <= reload_low_byte;   // see [R1]
         else
            count_low_byte <= 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // High count byte
   // Advances on its own tick in split mode, otherwise on a carry
   always_ff @(posedge I_CLK_SYS)
   begin
      if (I_RESET)
         count_high_byte <= BYTE_RESET;
      else if (wr_cnt_hi)
         count_high_byte <= I_SFR_WDATA;
      else if (adv_high)
      begin
         if (high_wrap)
            count_high_byte <= reload_high_byte; // see [R1] [R4]
         else
            count_high_byte <= count_high_byte + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt request level, see [R2] [R3] [R9] [R14]
   // A level, not a pulse: it stands while I_TIMER_IRQ_ENABLE and an enabled flag are set
   // One cycle behind the flags because it comes from a flip-flop
   always_ff @(posedge I_CLK_SYS)
   begin
      if (I_RESET)
         O_IRQ <= 1'b0;
      else
         O_IRQ <= I_TIMER_IRQ_ENABLE &&
                  (high_overflow_flag ||
                   (low_overflow_irq_enable && low_overflow_flag));
   end

   ////////////////////////////////////////////////////////////////////////
   // Read mux; unused bits 4 and 1 read zero, see [R12] [R11]
   // Unmapped addresses read zero so stray reads are harmless
   always_comb
   begin
      case (I_SFR_ADDR)
         ADDR_CTRL:      O_SFR_RDATA = {high_overflow_flag, low_overflow_flag,
                                        low_overflow_irq_enable, 1'b0,
                                        split_mode_select, high_run_control,
                                        1'b0, alternate_clock_select};
         ADDR_RELOAD_LO: O_SFR_RDATA = reload_low_byte;
         ADDR_RELOAD_HI: O_SFR_RDATA = reload_high_byte;
         ADDR_COUNT_LO:  O_SFR_RDATA = count_low_byte;
         ADDR_COUNT_HI:  O_SFR_RDATA = count_high_byte;
         default:        O_SFR_RDATA = 8'h00;
      endcase
   end
endmodule

// ==== verification/dat_timer_properties.sv ====
// Port-level checks for the dual-mode timer.
// Assumes one-cycle write strobes and combinational read data.
`timescale 1ns/1ps
module dat_timer_properties
   import dat_pkg::*;
(
   input wire logic       I_CLK_SYS,
   input wire logic       I_RESET,
   input wire logic [7:0] I_SFR_ADDR,
   input wire logic [7:0] I_SFR_WDATA,
   input wire logic       I_SFR_WE,
   input wire logic [7:0] O_SFR_RDATA,
   input wire logic       I_HIGH_FAST_CLOCK_SELECT,
   input wire logic       I_LOW_FAST_CLOCK_SELECT,
   input wire logic       I_TIMER_IRQ_ENABLE,
   input wire logic       O_IRQ
);
   logic [7:0] cfg;
   logic [7:0] rlo;
   logic       ctl;
   logic       q;
   default clocking @(posedge I_CLK_SYS); endclocking
   default disable iff (I_RESET);
   // Control address decode and no-write cycle
   assign ctl = I_SFR_ADDR == ADDR_CTRL;
   assign q = !I_SFR_WE && !I_RESET;
   // Shadow of written config bits and low reload
   always_ff @(posedge I_CLK_SYS)
   begin
      if (I_RESET)
      begin
         cfg <= 8'h00;
         rlo <= 8'h00;
      end
      else if (I_SFR_WE && ctl)
         cfg <= I_SFR_WDATA & 8'h2d;
      else if (I_SFR_WE && I_SFR_ADDR == ADDR_RELOAD_LO)
         rlo <= I_SFR_WDATA;
   end
   ///////////////////////////////////////////
   a_unused_zero:
      assert property (ctl |-> !O_SFR_RDATA[4] && !O_SFR_RDATA[1])
      else $error("unused control bit reads one");
   a_cfg_bits:
      assert property (ctl |-> (O_SFR_RDATA & 8'h2d) == cfg)
      else $error("control bits differ from last write");
   a_flags_sticky:
      assert property ($past(ctl) && ctl && $past(q) |->
         (O_SFR_RDATA[7:6] & $past(O_SFR_RDATA[7:6]))
         == $past(O_SFR_RDATA[7:6]))
      else $error("overflow flag cleared by hardware");
   a_irq_level:
      assert property ($past(ctl) && !$past(I_RESET) |->
         O_IRQ == $past(I_TIMER_IRQ_ENABLE && (O_SFR_RDATA[7]
         || O_SFR_RDATA[5] && O_SFR_RDATA[6])))
      else $error("interrupt request wrong for flags");
   a_hold_stopped:
      assert property ($past(q) && $stable(I_SFR_ADDR) && !ctl
         && !$past(cfg[BIT_RUN]) && !$past(cfg[BIT_SPLIT])
         |-> $stable(O_SFR_RDATA))
      else $error("stopped timer changed");
   a_split_hi_gated:
      assert property ($past(q) && $stable(I_SFR_ADDR)
         && I_SFR_ADDR == ADDR_COUNT_HI
         && $past(cfg[BIT_SPLIT] && !cfg[BIT_RUN]) |-> $stable(O_SFR_RDATA))
      else $error("high byte counted without run");
   a_step_word:
      assert property ($past(q) && $stable(I_SFR_ADDR)
         && I_SFR_ADDR == ADDR_COUNT_LO
         && $past(cfg[BIT_RUN] && !cfg[BIT_SPLIT] && I_HIGH_FAST_CLOCK_SELECT)
         && $past(O_SFR_RDATA) != BYTE_MAX
         |-> O_SFR_RDATA == $past(O_SFR_RDATA) + 8'h01)
      else $error("word counter missed a fast step");
   a_split_lo_step:
      assert property ($past(q) && $stable(I_SFR_ADDR)
         && I_SFR_ADDR == ADDR_COUNT_LO
         && $past(cfg[BIT_SPLIT] && I_LOW_FAST_CLOCK_SELECT)
         |-> O_SFR_RDATA == ($past(O_SFR_RDATA) == BYTE_MAX
         ? rlo : $past(O_SFR_RDATA) + 8'h01))
      else $error("low byte step or reload wrong");
   // Main scenarios reached
   c_irq: cover property (O_IRQ);
   c_split_run: cover property (cfg[BIT_SPLIT] && cfg[BIT_RUN]);
   c_ctl_write: cover property (I_SFR_WE && ctl);
   c_hi_flag: cover property (ctl && O_SFR_RDATA[BIT_HIGH_FLAG]);
endmodule

bind dat_timer dat_timer_properties u_props (.I_CLK_SYS, .I_RESET, .I_SFR_ADDR,
   .I_SFR_WDATA, .I_SFR_WE, .O_SFR_RDATA, .I_HIGH_FAST_CLOCK_SELECT,
   .I_LOW_FAST_CLOCK_SELECT, .I_TIMER_IRQ_ENABLE, .O_IRQ);

// ==== verification/dat_timer_tb.sv ====
// Self-checking bench for the dual-mode timer via its register port.
// Assumes the checker binds itself to the design.
`timescale 1ns/1ps
module dat_timer_tb
   import dat_pkg::*;
;
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic [7:0] addr = ADDR_COUNT_LO;
   logic [7:0] wdata = 8'h00;
   logic       we = 1'b0;
   logic       osc = 1'b0;
   logic       hfast = 1'b0;
   logic       lfast = 1'b0;
   logic       ien = 1'b1;
   logic       cap = 1'b0;
   logic [7:0] rdata;
   logic       irq;
   int         err_count = 0;
   int         n_compared = 0;
   // Core clock and an external source at half its rate
   always #5 clk = ~clk;
   always @(negedge clk) osc <= ~osc;
   dat_timer DUT (.I_CLK_SYS(clk), .I_RESET(rst), .I_SFR_ADDR(addr),
      .I_SFR_WDATA(wdata), .I_SFR_WE(we), .O_SFR_RDATA(rdata), .I_EXT_OSC(osc),
      .I_HIGH_FAST_CLOCK_SELECT(hfast), .I_LOW_FAST_CLOCK_SELECT(lfast),
      .I_TIMER_IRQ_ENABLE(ien), .I_CAPTURE_ENABLE_BIT(cap), .O_IRQ(irq));
   ///////////////////////////////////////////
   // Access tasks; strobe stays up between back-to-back writes
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      addr = a;
      wdata = d;
      we = 1'b1;
   endtask
   task idle;
      @(negedge clk);
      we = 1'b0;
   endtask
   task cmp(input logic [7:0] g, input logic [7:0] e);
      n_compared++;
      if (g !== e)
      begin
         err_count++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask
   task chk(input logic [7:0] a, input logic [7:0] e);
      @(negedge clk);
      addr = a;
      #1;
      cmp(rdata, e);
   endtask
   task chkq(input logic e);
      @(negedge clk);
      #1;
      cmp({7'h00, irq}, {7'h00, e});
   endtask
   task chkr(input logic [7:0] lo, input logic [7:0] hi);
      @(negedge clk);
      addr = ADDR_COUNT_LO;
      #1;
      cmp({7'h00, rdata >= lo && rdata <= hi}, 8'h01);
   endtask
   task wrap_up;
      if (err_count == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   ///////////////////////////////////////////
   // Watchdog against a hang
   initial
   begin
      #50us;
      err_count++;
      wrap_up;
   end
   // Main sequence
   initial
   begin
      repeat (12) @(posedge clk);
      @(negedge clk) rst = 1'b0;
      hfast = 1'b1;
      repeat (3) @(negedge clk);
      chk(ADDR_CTRL, 8'h00);
      chk(ADDR_RELOAD_HI, 8'h00);
      chk(8'hc9, 8'h00);
      wr(ADDR_COUNT_LO, 8'hfe);
      wr(ADDR_COUNT_HI, 8'hff);
      wr(ADDR_RELOAD_LO, 8'h34);
      wr(ADDR_RELOAD_HI, 8'h12);
      idle;
      wr(ADDR_CTRL, 8'h04);
      wr(ADDR_CTRL, 8'h00);
      idle;
      chk(ADDR_COUNT_LO, 8'hff);
      wr(ADDR_CTRL, 8'h04);
      wr(ADDR_CTRL, 8'h00);
      idle;
      chk(ADDR_COUNT_LO, 8'h34);
      chk(ADDR_COUNT_HI, 8'h12);
      chk(ADDR_CTRL, 8'hc0);
      chkq(1'b1);
      repeat (20) @(negedge clk);
      chk(ADDR_CTRL, 8'hc0);
      wr(ADDR_CTRL, 8'h00);
      idle;
      chkq(1'b0);
      wr(ADDR_COUNT_LO, 8'hff);
      wr(ADDR_COUNT_HI, 8'h00);
      wr(ADDR_CTRL, 8'h24);
      wr(ADDR_CTRL, 8'h20);
      idle;
      chk(ADDR_COUNT_HI, 8'h01);
      chk(ADDR_CTRL, 8'h60);
      chkq(1'b1);
      wr(ADDR_CTRL, 8'h40);
      idle;
      chkq(1'b0);
      wr(ADDR_CTRL, 8'h12);
      idle;
      chk(ADDR_CTRL, 8'h00);
      wr(ADDR_COUNT_LO, 8'h00);
      wr(ADDR_COUNT_HI, 8'h00);
      wr(ADDR_CTRL, 8'h04);
      idle;
      chk(ADDR_COUNT_LO, 8'h01);
      chk(ADDR_COUNT_LO, 8'h02);
      chk(ADDR_COUNT_LO, 8'h03);
      wr(ADDR_CTRL, 8'h00);
      wr(ADDR_COUNT_LO, 8'h00);
      wr(ADDR_CTRL, 8'h08);
      idle;
      repeat (120) @(negedge clk);
      chkr(8'h09, 8'h0b);
      wr(ADDR_COUNT_LO, 8'h00);
      wr(ADDR_CTRL, 8'h09);
      idle;
      repeat (160) @(negedge clk);
      chkr(8'h08, 8'h0b);
      // Capture enable raised to show it is ignored
      @(negedge clk);
      lfast = 1'b1;
      cap = 1'b1;
      wr(ADDR_COUNT_HI, 8'hff);
      wr(ADDR_COUNT_LO, 8'hfe);
      wr(ADDR_CTRL, 8'h08);
      idle;
      chk(ADDR_COUNT_HI, 8'hff);
      repeat (130) @(negedge clk);
      @(negedge clk) addr = ADDR_COUNT_LO;
      repeat (130) @(negedge clk);
      chk(ADDR_COUNT_HI, 8'hff);
      chk(ADDR_CTRL, 8'h48);
      wr(ADDR_CTRL, 8'h4c);
      wr(ADDR_CTRL, 8'h48);
      idle;
      chk(ADDR_COUNT_HI, 8'h12);
      chk(ADDR_CTRL, 8'hc8);
      chkq(1'b1);
      wr(ADDR_CTRL, 8'h28);
      idle;
      repeat (210) @(negedge clk);
      chk(ADDR_CTRL, 8'h68);
      chkq(1'b1);
      @(negedge clk) ien = 1'b0;
      chkq(1'b0);
      wrap_up;
   end
endmodule
